// File: hdl/scr_system_control.v
// system control register bank with ahb-lite slave and select logic
`timescale 1ns/1ps
`default_nettype none
`include "scr_defines.vh"

// Operation
// - misc_control_zero bit7 inverts comparator 2 output
// - misc_control_zero bit6 picks timer clock: pin or interrupt
// - unimplemented bits read zero, writes ignored
// - misc_control_zero bit3 picks peripheral clock prescaler divisor
// - misc_control_zero bit1 read-only low voltage result
// - misc_control_zero bit0 enables low voltage detector
// - ext_interrupt_control bit7 inverts debounced external interrupt
// - ext_interrupt_control bit6 picks interrupt pin or comparator 0
// - comparator_reference_a bits5-3 comparator 2 second reference
// - comparator_reference_a bits2-0 comparator 1 reference
// - comparator_reference_b bit6 inverts comparator 3 output
// - comparator_reference_b bits5-3 comparator 3 reference
// - comparator_reference_b bits2-0 comparator 2 first reference
module scr_system_control #(
  parameter PCK_DIV0 = 2,
  parameter PCK_DIV1 = 4,
  parameter DIV_W = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata_q,
  output reg hreadyout_q,
  output reg hresp_q,
  input wire cmp0_output,
  input wire cmp2_raw,
  input wire cmp3_raw,
  input wire timer_zero_pin,
  input wire ext_irq_pin,
  input wire low_voltage_flag,
  output reg cmp2_out_q,
  output reg cmp3_out_q,
  output reg timer_zero_clk_q,
  output reg ext_interrupt_zero_q,
  output reg periph_clk_tick_q,
  output reg low_voltage_detect_enable_q,
  output reg [2:0] cmp1_ref_select_q,
  output reg [2:0] cmp2_ref_a_select_q,
  output reg [2:0] cmp2_ref_b_select_q,
  output reg [2:0] cmp3_ref_select_q,
  output reg irq_q
);

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  reg [7:0] misc_control_zero_q;
  reg [7:0] ext_interrupt_control_q;
  reg [7:0] comparator_reference_a_q;
  reg [7:0] comparator_reference_b_q;
  reg [7:0] status_q;
  reg [7:0] status_d;
  reg [7:0] mask_q;
  reg [7:0] wr_addr_q;
  reg wr_pend_q;
  reg lv_seen_q;
  reg ext_prev_q;
  reg [DIV_W-1:0] div_cnt_q;
  reg [7:0] rd_val;
  reg [7:0] status_clr;
  wire addr_phase;
  wire addr_in_bank;
  wire [7:0] addr_lo;
  wire [7:0] wdata;
  wire irq_src;
  wire irq_clean;
  wire ext_int_d;
  wire [DIV_W-1:0] div_limit;
  wire [7:0] status_evt;
  wire lv_rise;
  wire ext_rise;

  assign addr_phase = hsel & hready & (htrans == `SCR_AHB_TRANS_NONSEQ);
  // upper address bits must be clear, else the access lands on an unmapped slot
  assign addr_in_bank = (haddr[31:8] == 24'h000000);
  assign addr_lo = addr_in_bank ? haddr[7:0] : 8'hFF;
  assign wdata = hwdata[7:0];

  // ----------------------------------------------------------------------------
  // ahb-lite slave: zero wait, always okay
  // ----------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b0;
      hresp_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      wr_pend_q <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_q <= addr_lo;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------------------
  // read value chosen in the address phase so hrdata is a flop in the data phase
  always @* begin
    rd_val = 8'h00;
    status_clr = 8'h00;
    if (addr_phase && !hwrite) begin
      case (addr_lo)
        `SCR_OFF_MISC_CONTROL_ZERO: begin
          rd_val = misc_control_zero_q;
        end
        `SCR_OFF_EXT_INTERRUPT_CONTROL: begin
          rd_val = ext_interrupt_control_q;
        end
        `SCR_OFF_COMPARATOR_REFERENCE_A: begin
          rd_val = comparator_reference_a_q;
        end
        `SCR_OFF_COMPARATOR_REFERENCE_B: begin
          rd_val = comparator_reference_b_q;
        end
        `SCR_OFF_IRQ_STATUS: begin
          rd_val = status_q;
          status_clr = status_q;
        end
        `SCR_OFF_IRQ_MASK: begin
          rd_val = mask_q;
        end
        default: begin
          rd_val = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // read data register
  // ----------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (addr_phase) begin
      hrdata_q <= {24'h000000, rd_val};
    end
  end

  // ----------------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------------
  // a write in the data phase lands at the end of that phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      misc_control_zero_q <= `SCR_CTRL_RESET;
      ext_interrupt_control_q <= `SCR_CTRL_RESET;
      comparator_reference_a_q <= `SCR_CTRL_RESET;
      comparator_reference_b_q <= `SCR_CTRL_RESET;
      mask_q <= 8'h00;
    end else begin
      // status bit follows the detector; software cannot write it
      misc_control_zero_q[`SCR_LOW_VOLTAGE_FLAG_BIT] <= low_voltage_flag &
        misc_control_zero_q[`SCR_LOW_VOLTAGE_DETECT_ENABLE_BIT];
      if (wr_pend_q) begin
        case (wr_addr_q)
          `SCR_OFF_MISC_CONTROL_ZERO: begin
            misc_control_zero_q[7:6] <= wdata[7:6];
            misc_control_zero_q[5:4] <= 2'h0;
            misc_control_zero_q[`SCR_PERIPH_CLK_PRESCALE_SELECT_BIT] <=
              wdata[`SCR_PERIPH_CLK_PRESCALE_SELECT_BIT];
            misc_control_zero_q[2] <= 1'b0;
            misc_control_zero_q[`SCR_LOW_VOLTAGE_DETECT_ENABLE_BIT] <=
              wdata[`SCR_LOW_VOLTAGE_DETECT_ENABLE_BIT];
          end
          `SCR_OFF_EXT_INTERRUPT_CONTROL: begin
            ext_interrupt_control_q <= wdata & `SCR_EXT_INTERRUPT_CONTROL_WR_MASK;
          end
          `SCR_OFF_COMPARATOR_REFERENCE_A: begin
            comparator_reference_a_q <= wdata & `SCR_COMPARATOR_REFERENCE_A_WR_MASK;
          end
          `SCR_OFF_COMPARATOR_REFERENCE_B: begin
            comparator_reference_b_q <= wdata & `SCR_COMPARATOR_REFERENCE_B_WR_MASK;
          end
          `SCR_OFF_IRQ_MASK: begin
            mask_q <= wdata & `SCR_IRQ_MASK_BITS;
          end
          default: begin
            mask_q <= mask_q;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // external interrupt path
  // ----------------------------------------------------------------------------
  assign irq_src = ext_interrupt_control_q[`SCR_EXT_IRQ_SOURCE_SELECT_BIT] ? cmp0_output : ext_irq_pin;

  scr_debounce #(
    .CODE_W(6)
  ) u_debounce (
    .hclk(hclk),
    .hresetn(hresetn),
    .raw_in(irq_src),
    .code(ext_interrupt_control_q[`SCR_DEBOUNCE_MSB:`SCR_DEBOUNCE_LSB]),
    .clean_q(irq_clean)
  );

  assign ext_int_d = irq_clean ^ ext_interrupt_control_q[`SCR_EXT_IRQ_INVERT_BIT];

  // ----------------------------------------------------------------------------
  // peripheral clock prescaler
  // ----------------------------------------------------------------------------
  // emits a one-cycle tick rather than a gated clock, keeping one clock domain
  assign div_limit = misc_control_zero_q[`SCR_PERIPH_CLK_PRESCALE_SELECT_BIT] ?
    PCK_DIV1[DIV_W-1:0] : PCK_DIV0[DIV_W-1:0];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= {DIV_W{1'b0}};
      periph_clk_tick_q <= 1'b0;
    end else if (div_cnt_q + 1'b1 >= div_limit) begin
      div_cnt_q <= {DIV_W{1'b0}};
      periph_clk_tick_q <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
      periph_clk_tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // select and steering outputs
  // ----------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp2_out_q <= 1'b0;
      cmp3_out_q <= 1'b0;
      timer_zero_clk_q <= 1'b0;
      ext_interrupt_zero_q <= 1'b0;
      low_voltage_detect_enable_q <= 1'b0;
      cmp1_ref_select_q <= 3'h0;
      cmp2_ref_a_select_q <= 3'h0;
      cmp2_ref_b_select_q <= 3'h0;
      cmp3_ref_select_q <= 3'h0;
    end else begin
      cmp2_out_q <= cmp2_raw ^ misc_control_zero_q[`SCR_CMP2_OUT_INVERT_BIT];
      cmp3_out_q <= cmp3_raw ^ comparator_reference_b_q[`SCR_CMP3_OUT_INVERT_BIT];
      timer_zero_clk_q <= misc_control_zero_q[`SCR_TIMER_ZERO_EXT_CLK_SELECT_BIT] ?
        ext_int_d : timer_zero_pin;
      ext_interrupt_zero_q <= ext_int_d;
      low_voltage_detect_enable_q <= misc_control_zero_q[`SCR_LOW_VOLTAGE_DETECT_ENABLE_BIT];
      cmp2_ref_b_select_q <= comparator_reference_a_q[`SCR_REF_HI_MSB:`SCR_REF_HI_LSB];
      cmp1_ref_select_q <= comparator_reference_a_q[`SCR_REF_LO_MSB:`SCR_REF_LO_LSB];
      cmp3_ref_select_q <= comparator_reference_b_q[`SCR_REF_HI_MSB:`SCR_REF_HI_LSB];
      cmp2_ref_a_select_q <= comparator_reference_b_q[`SCR_REF_LO_MSB:`SCR_REF_LO_LSB];
    end
  end

  // ----------------------------------------------------------------------------
  // interrupt status, mask and output
  // ----------------------------------------------------------------------------
  // events are rising edges, so a level that stays up sets its bit only once
  assign lv_rise = misc_control_zero_q[`SCR_LOW_VOLTAGE_FLAG_BIT] & ~lv_seen_q;
  assign ext_rise = ext_int_d & ~ext_prev_q;
  assign status_evt = {6'h00, ext_rise, lv_rise};

  // ----------------------------------------------------------------------------
  // status next value
  // ----------------------------------------------------------------------------
  // set beats the read-clear so an event in the clearing cycle survives
  always @* begin
    status_d = (status_q & ~status_clr) | status_evt;
  end

  // ----------------------------------------------------------------------------
  // status register and interrupt line
  // ----------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= 8'h00;
      lv_seen_q <= 1'b0;
      ext_prev_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      lv_seen_q <= misc_control_zero_q[`SCR_LOW_VOLTAGE_FLAG_BIT];
      ext_prev_q <= ext_int_d;
      irq_q <= |(status_d & mask_q);
    end
  end

endmodule // scr_system_control
`default_nettype wire

// File: pkg/scr_defines.vh
// register map, field positions and reset values of the system control bank
`ifndef SCR_DEFINES_VH
`define SCR_DEFINES_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define SCR_OFF_MISC_CONTROL_ZERO 8'h00
`define SCR_OFF_EXT_INTERRUPT_CONTROL 8'h04
`define SCR_OFF_COMPARATOR_REFERENCE_A 8'h08
`define SCR_OFF_COMPARATOR_REFERENCE_B 8'h0C
`define SCR_OFF_IRQ_STATUS 8'h10
`define SCR_OFF_IRQ_MASK 8'h14

// ----------------------------------------------------------------------------
// misc_control_zero fields
// ----------------------------------------------------------------------------
`define SCR_CMP2_OUT_INVERT_BIT 7
`define SCR_TIMER_ZERO_EXT_CLK_SELECT_BIT 6
`define SCR_PERIPH_CLK_PRESCALE_SELECT_BIT 3
`define SCR_LOW_VOLTAGE_FLAG_BIT 1
`define SCR_LOW_VOLTAGE_DETECT_ENABLE_BIT 0
`define SCR_MISC_CONTROL_ZERO_WR_MASK 8'hC9

// ----------------------------------------------------------------------------
// ext_interrupt_control fields
// ----------------------------------------------------------------------------
`define SCR_EXT_IRQ_INVERT_BIT 7
`define SCR_EXT_IRQ_SOURCE_SELECT_BIT 6
`define SCR_DEBOUNCE_MSB 5
`define SCR_DEBOUNCE_LSB 0
`define SCR_EXT_INTERRUPT_CONTROL_WR_MASK 8'hFF

// ----------------------------------------------------------------------------
// comparator reference fields
// ----------------------------------------------------------------------------
`define SCR_REF_HI_MSB 5
`define SCR_REF_HI_LSB 3
`define SCR_REF_LO_MSB 2
`define SCR_REF_LO_LSB 0
`define SCR_CMP3_OUT_INVERT_BIT 6
`define SCR_COMPARATOR_REFERENCE_A_WR_MASK 8'h3F
`define SCR_COMPARATOR_REFERENCE_B_WR_MASK 8'h7F

// ----------------------------------------------------------------------------
// interrupt status / mask layout
// ----------------------------------------------------------------------------
`define SCR_IRQ_LOW_VOLTAGE_BIT 0
`define SCR_IRQ_EXT_EDGE_BIT 1
`define SCR_IRQ_MASK_BITS 8'h03

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define SCR_CTRL_RESET 8'h00
`define SCR_DEBOUNCE_BYPASS 6'h00
`define SCR_AHB_TRANS_NONSEQ 2'h2

`endif

// File: hdl/scr_debounce.v
// external interrupt debounce filter, one clock per code step
`timescale 1ns/1ps
`default_nettype none
`include "scr_defines.vh"

module scr_debounce #(
  parameter CODE_W = 6
) (
  input wire hclk,
  input wire hresetn,
  input wire raw_in,
  input wire [CODE_W-1:0] code,
  output reg clean_q
);

  reg [CODE_W-1:0] cnt_q;

  // ----------------------------------------------------------------------------
  // filter
  // ----------------------------------------------------------------------------
  // a level must hold for code cycles before it is passed on
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= {CODE_W{1'b0}};
      clean_q <= 1'b0;
    end else if (code == `SCR_DEBOUNCE_BYPASS) begin
      cnt_q <= {CODE_W{1'b0}};
      clean_q <= raw_in;
    end else if (raw_in == clean_q) begin
      cnt_q <= {CODE_W{1'b0}};
    end else if (cnt_q + 1'b1 >= code) begin
      cnt_q <= {CODE_W{1'b0}};
      clean_q <= raw_in;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule // scr_debounce
`default_nettype wire

// File: dv/scr_system_control_properties.sv
// concurrent checks on the ports of the system control bank
`timescale 1ns/1ps
`default_nettype none
module scr_props #(
  parameter PCK_DIV0 = 2,
  parameter PCK_DIV1 = 4
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire cmp0_output,
  input wire cmp2_raw,
  input wire cmp3_raw,
  input wire timer_zero_pin,
  input wire ext_irq_pin,
  input wire cmp2_out_q,
  input wire cmp3_out_q,
  input wire timer_zero_clk_q,
  input wire ext_interrupt_zero_q,
  input wire periph_clk_tick_q,
  input wire low_voltage_detect_enable_q,
  input wire [2:0] cmp1_ref_select_q,
  input wire [2:0] cmp2_ref_a_select_q,
  input wire [2:0] cmp2_ref_b_select_q,
  input wire [2:0] cmp3_ref_select_q
);
  // ----------------------------------------
  // shadow registers from observed writes
  // ----------------------------------------
  reg w_q;
  reg [7:0] a_q;
  reg [7:0] r0;
  reg [7:0] r1;
  reg [7:0] r2;
  reg [7:0] r3;
  reg [1:0] age;
  reg [7:0] tc;
  reg ok;
  wire src = r1[6] ? cmp0_output : ext_irq_pin;
  wire up = age == 2'h3;
  wire wr = hready && w_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_q <= 1'b0;
      a_q <= 8'h00;
      r0 <= 8'h00;
      r1 <= 8'h00;
      r2 <= 8'h00;
      r3 <= 8'h00;
      age <= 2'h0;
      tc <= 8'h00;
      ok <= 1'b0;
    end else begin
      if (!up) age <= age + 2'h1;
      if (hready) w_q <= hsel && htrans == 2'h2 && hwrite;
      if (hready) a_q <= haddr[7:0];
      if (wr && a_q == 8'h00) r0 <= hwdata[7:0];
      if (wr && a_q == 8'h04) r1 <= hwdata[7:0];
      if (wr && a_q == 8'h08) r2 <= hwdata[7:0];
      if (wr && a_q == 8'h0C) r3 <= hwdata[7:0];
      tc <= periph_clk_tick_q ? 8'h00 : tc + 8'h01;
      if (periph_clk_tick_q) ok <= 1'b1;
      // a divisor change spoils the interval it falls in
      if (wr && a_q == 8'h00 && hwdata[3] != r0[3]) ok <= 1'b0;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_cmp2_invert: assert property (
    up |-> cmp2_out_q == ($past(cmp2_raw) ^ $past(r0[7]))) else $error("cmp2 polarity wrong");
  a_cmp3_invert: assert property (
    up |-> cmp3_out_q == ($past(cmp3_raw) ^ $past(r3[6]))) else $error("cmp3 polarity wrong");
  a_timer_pin_path: assert property (
    up && !$past(r0[6]) |-> timer_zero_clk_q == $past(timer_zero_pin)) else $error("timer clock not pin");
  a_lvd_enable: assert property (
    up |-> low_voltage_detect_enable_q == $past(r0[0])) else $error("detector enable wrong");
  a_ref_a_fields: assert property (
    up |-> {cmp2_ref_b_select_q, cmp1_ref_select_q} == $past(r2[5:0])) else $error("ref a selects wrong");
  a_ref_b_fields: assert property (
    up |-> {cmp3_ref_select_q, cmp2_ref_a_select_q} == $past(r3[5:0])) else $error("ref b selects wrong");
  a_ext_bypass_path: assert property (
    (up && r1[5:0] == 6'h00) [*3] |-> ext_interrupt_zero_q == ($past(src, 2) ^ $past(r1[7])))
    else $error("bypassed interrupt path wrong");
  a_tick_period: assert property (
    up && ok && periph_clk_tick_q |-> tc == (r0[3] ? PCK_DIV1 : PCK_DIV0) - 1) else $error("tick period wrong");
endmodule // scr_props

bind scr_system_control scr_props #(.PCK_DIV0(PCK_DIV0), .PCK_DIV1(PCK_DIV1)) u_props (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .cmp0_output, .cmp2_raw, .cmp3_raw, .timer_zero_pin, .ext_irq_pin,
  .cmp2_out_q, .cmp3_out_q, .timer_zero_clk_q, .ext_interrupt_zero_q, .periph_clk_tick_q,
  .low_voltage_detect_enable_q, .cmp1_ref_select_q, .cmp2_ref_a_select_q, .cmp2_ref_b_select_q, .cmp3_ref_select_q);
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the system control bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // stimulus, bus tasks and checks
  // ----------------------------------------
  localparam D0 = 2;
  localparam D1 = 4;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg cmp0 = 1'b0, c2 = 1'b0, c3 = 1'b0, tp = 1'b0, ep = 1'b0, lvf = 1'b0, quiet = 1'b1;
  reg [15:0] lf = 16'h0037;
  reg [31:0] rd;
  reg [7:0] k;
  reg [7:0] d;
  reg [1:0] j;
  integer mismatches = 0, comparisons = 0, cyc = 0, n;
  wire [31:0] hrdata_q;
  wire hreadyout_q, hresp, c2o, c3o, tzc, eiz, tick, lvde, irq;
  wire [2:0] s1, s2a, s2b, s3;
  always #12.5 hclk = ~hclk;
  scr_system_control #(.PCK_DIV0(D0), .PCK_DIV1(D1)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_q),
    .hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q), .hresp_q(hresp), .cmp0_output(cmp0), .cmp2_raw(c2), .cmp3_raw(c3),
    .timer_zero_pin(tp), .ext_irq_pin(ep), .low_voltage_flag(lvf), .cmp2_out_q(c2o), .cmp3_out_q(c3o),
    .timer_zero_clk_q(tzc), .ext_interrupt_zero_q(eiz), .periph_clk_tick_q(tick),
    .low_voltage_detect_enable_q(lvde), .cmp1_ref_select_q(s1), .cmp2_ref_a_select_q(s2a),
    .cmp2_ref_b_select_q(s2b), .cmp3_ref_select_q(s3), .irq_q(irq));
  function [15:0] nx(input [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [7:0] msk(input [1:0] r);
    msk = r == 2'h0 ? 8'hC9 : r == 2'h1 ? 8'hFF : r == 2'h2 ? 8'h3F : 8'h7F;
  endfunction
  task tally_and_finish;
    begin
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cy(input integer c);
    repeat (c) @(posedge hclk);
  endtask
  // no fixed latency assumed: waits on hready in both phases
  task xfer(input [7:0] a, input w, input [7:0] wd);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (!hreadyout_q) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      @(posedge hclk);
      while (!hreadyout_q) @(posedge hclk);
      rd = hrdata_q;
    end
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
    if (!quiet) begin
      lf <= nx(lf);
      {cmp0, c2, c3, tp, ep} <= lf[4:0];
    end
  end
  initial begin
    cy(10);
    hresetn <= 1'b1;
    cy(2);
    for (k = 8'h00; k < 8'h1C; k = k + 8'h04) begin
      xfer(k, 1'b0, 8'h00);
      chk(rd, 0);
    end
    // inputs held quiet until here so no stray event sets status before its first read
    quiet <= 1'b0;
    for (n = 0; n < 32; n = n + 1) begin
      j = n[1:0];
      d = lf[7:0];
      xfer({4'h0, j, 2'h0}, 1'b1, d);
      xfer({4'h0, j, 2'h0}, 1'b0, 8'h00);
      chk(rd, {24'h0, d & msk(j)});
    end
    xfer(8'h1C, 1'b1, 8'hFF);
    xfer(8'h1C, 1'b0, 8'h00);
    chk(rd, 0);
    chk(hresp, 0);
    xfer(8'h14, 1'b1, 8'h00);
    xfer(8'h00, 1'b1, 8'h00);
    xfer(8'h10, 1'b0, 8'h00);
    lvf <= 1'b1;
    xfer(8'h00, 1'b1, 8'h01);
    cy(3);
    chk(irq, 0);
    xfer(8'h14, 1'b1, 8'h01);
    cy(2);
    chk(irq, 1);
    xfer(8'h00, 1'b0, 8'h00);
    chk(rd, 8'h03);
    xfer(8'h00, 1'b1, 8'h02);
    xfer(8'h00, 1'b0, 8'h00);
    chk(rd, 8'h00);
    xfer(8'h10, 1'b0, 8'h00);
    chk(rd[0], 1);
    cy(2);
    chk(irq, 0);
    quiet <= 1'b1;
    lvf <= 1'b0;
    cy(1);
    ep <= 1'b0;
    tp <= 1'b0;
    cmp0 <= 1'b1;
    xfer(8'h04, 1'b1, 8'h80);
    cy(4);
    chk(eiz, 1);
    xfer(8'h04, 1'b1, 8'h40);
    cy(4);
    chk(eiz, 1);
    xfer(8'h04, 1'b1, 8'h05);
    cy(8);
    ep <= 1'b1;
    cy(2);
    ep <= 1'b0;
    cy(6);
    chk(eiz, 0);
    xfer(8'h10, 1'b0, 8'h00);
    ep <= 1'b1;
    cy(3);
    chk(eiz, 0);
    cy(6);
    chk(eiz, 1);
    xfer(8'h10, 1'b0, 8'h00);
    chk(rd, 8'h02);
    xfer(8'h00, 1'b1, 8'h40);
    cy(3);
    chk(tzc, 1);
    xfer(8'h00, 1'b1, 8'h00);
    cy(3);
    chk(tzc, 0);
    for (n = 0; n < 2; n = n + 1) begin
      xfer(8'h00, 1'b1, {4'h0, n[0], 3'h0});
      cy(8);
      k = 8'h00;
      repeat (40) begin
        @(posedge hclk);
        k = k + {7'h0, tick};
      end
      chk(k, n ? 40 / D1 : 40 / D0);
    end
    xfer(8'h04, 1'b1, 8'hFF);
    hresetn <= 1'b0;
    cy(2);
    hresetn <= 1'b1;
    cy(2);
    xfer(8'h04, 1'b0, 8'h00);
    chk(rd, 0);
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
